// ### inc/tmai_pkg.sv
// Types shared by the alarm interrupt block
package tmai_pkg;

	// Raw level conditions of the first status register
	typedef struct packed {
		logic eightZeroDetect;
		logic sixteenZeroDetect;
		logic carrierLoss;
		logic yellowAlarm;
		logic lossOfSync;
		logic zeroSubCodewordSeen;
		logic blueAlarm;
		logic frameAlignChange;
	} tmai_alarm_t;

	// One-cycle event pulses from the framer and counters
	typedef struct packed {
		logic framingBitSeen;
		logic frameBitError;
		logic oofEvent;
		logic crcErrEvent;
		logic bpvEvent;
	} tmai_event_t;

	// Read path state
	typedef enum logic [1:0] {
		TMAI_RD_IDLE = 2'b01,
		TMAI_RD_DATA = 2'b10
	} tmai_rd_t;

endpackage

// ### inc/tmai_regs.svh
// Register offsets, bit positions and reset values of the alarm interrupt block
`ifndef TMAI_REGS_SVH
`define TMAI_REGS_SVH

// Register offsets on the plain register port
`define TMAI_ADDR_W          4
`define TMAI_OFF_STATUS_ONE  4'h0
`define TMAI_OFF_MASK_ONE    4'h1
`define TMAI_OFF_STATUS_TWO  4'h2
`define TMAI_OFF_MASK_TWO    4'h3
`define TMAI_OFF_CONTROL     4'h4

// Bit positions of the first status and mask registers
`define TMAI_B1_EIGHT_ZERO   7
`define TMAI_B1_SIXTEEN_ZERO 6
`define TMAI_B1_CARRIER_LOSS 5
`define TMAI_B1_YELLOW       4
`define TMAI_B1_LOSS_SYNC    3
`define TMAI_B1_ZERO_SUB     2
`define TMAI_B1_BLUE         1
`define TMAI_B1_ALIGN_CHG    0

// Bit positions of the second status and mask registers
`define TMAI_B2_SEVERE_FRM   7
`define TMAI_B2_CL_CLEAR     6
`define TMAI_B2_BLUE_CLEAR   5
`define TMAI_B2_FRAME_ERR    4
`define TMAI_B2_FE_SAT       3
`define TMAI_B2_OOF_SAT      2
`define TMAI_B2_CRC_SAT      1
`define TMAI_B2_BPV_SAT      0

// Control register bit: burst-mode reads keep status bits
`define TMAI_CTL_BURST       0

// Reset values
`define TMAI_RST_MASK        8'h00
`define TMAI_RST_STATUS      8'h00

// Saturation maxima of the error counters
`define TMAI_SAT_MAX8        8'hff
`define TMAI_SAT_MAX16       16'hffff

// Severe framing window: errors within a span of framing bits
`define TMAI_SEF_SPAN        6
`define TMAI_SEF_ERRS        2

`endif

// ### rtl/tmai_alarm_irq.sv
// Alarm status latching, interrupt masks and interrupt output
`timescale 1ns/1ps
`include "tmai_regs.svh"

module tmai_alarm_irq
	import tmai_pkg::*;
#(
	parameter int CNT8_W  = 8,
	parameter int CNT16_W = 16
) (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst_b,
	// Register port
	input  wire logic [`TMAI_ADDR_W-1:0] regAddr,
	input  wire logic [7:0]              regWrData,
	input  wire logic                    regWrStb,
	input  wire logic                    regRdStb,
	output logic      [7:0]              regRdData,
	// Alarm levels and event pulses from the framer, same clock
	input  wire tmai_alarm_t             alarmLevel,
	input  wire tmai_event_t             eventPulse,
	// Counter values, same clock
	input  wire logic [CNT8_W-1:0]       frameErrorCount,
	input  wire logic [CNT8_W-1:0]       outOfFrameCount,
	input  wire logic [CNT8_W-1:0]       crcErrorCount,
	input  wire logic [CNT16_W-1:0]      bipolarViolCount,
	// Interrupt to the host, active low
	output logic                         irq_b
);

	tmai_alarm_t     status1_q;
	logic [7:0]      status2_q;
	logic [7:0]      status2Set;
	logic [7:0]      status2Live;
	logic [7:0]      rxIrqMaskOne_q;
	logic [7:0]      rxIrqMaskTwo_q;
	logic            burstMode_q;
	logic            carrierLoss_q;
	logic            blueAlarm_q;
	logic [`TMAI_SEF_SPAN-1:0] frmErrHist_q;
	logic [`TMAI_SEF_SPAN-1:0] frmErrHist_d;
	logic            rdStatus1;
	logic            rdStatus2;
	logic            irqAny;

	// Counts ones in a framing error window
	function automatic logic [2:0] count_ones(
		input logic [`TMAI_SEF_SPAN-1:0] v
	);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < `TMAI_SEF_SPAN; i++) begin
			n = n + {2'b00, v[i]};
		end
		return n;
	endfunction

	// True when a counter sits at its all-ones maximum
	function automatic logic at_max8(input logic [CNT8_W-1:0] c);
		return c == CNT8_W'(`TMAI_SAT_MAX8);
	endfunction

	assign rdStatus1 = regRdStb && (regAddr == `TMAI_OFF_STATUS_ONE);
	assign rdStatus2 = regRdStb && (regAddr == `TMAI_OFF_STATUS_TWO);

	// Mask and control registers written by software
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rxIrqMaskOne_q <= `TMAI_RST_MASK;
			rxIrqMaskTwo_q <= `TMAI_RST_MASK;
			burstMode_q    <= 1'b0;
		end else if (regWrStb) begin
			case (regAddr)
				`TMAI_OFF_MASK_ONE: rxIrqMaskOne_q <= regWrData;
				`TMAI_OFF_MASK_TWO: rxIrqMaskTwo_q <= regWrData;
				`TMAI_OFF_CONTROL:  burstMode_q <= regWrData[`TMAI_CTL_BURST];
				default: ;
			endcase
		end
	end

	// History of previous alarm levels for clear-edge detection
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			carrierLoss_q <= 1'b0;
			blueAlarm_q   <= 1'b0;
		end else begin
			carrierLoss_q <= alarmLevel.carrierLoss;
			blueAlarm_q   <= alarmLevel.blueAlarm;
		end
	end

	// Shift in one entry per framing bit, 1 for an error
	always_comb begin
		frmErrHist_d = frmErrHist_q;
		if (eventPulse.framingBitSeen) begin
			frmErrHist_d = {frmErrHist_q[`TMAI_SEF_SPAN-2:0],
				eventPulse.frameBitError};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			frmErrHist_q <= '0;
		end else begin
			frmErrHist_q <= frmErrHist_d;
		end
	end

	// Set terms of the second status register
	always_comb begin
		status2Set = 8'h00;
		status2Set[`TMAI_B2_SEVERE_FRM] = eventPulse.framingBitSeen &&
			eventPulse.frameBitError &&
			(count_ones(frmErrHist_d) >= 3'(`TMAI_SEF_ERRS));
		status2Set[`TMAI_B2_CL_CLEAR] = carrierLoss_q &&
			!alarmLevel.carrierLoss;
		status2Set[`TMAI_B2_BLUE_CLEAR] = blueAlarm_q &&
			!alarmLevel.blueAlarm;
		status2Set[`TMAI_B2_FRAME_ERR] = eventPulse.frameBitError;
		status2Set[`TMAI_B2_FE_SAT] = eventPulse.frameBitError &&
			at_max8(frameErrorCount);
		status2Set[`TMAI_B2_OOF_SAT] = eventPulse.oofEvent &&
			at_max8(outOfFrameCount);
		status2Set[`TMAI_B2_CRC_SAT] = eventPulse.crcErrEvent &&
			at_max8(crcErrorCount);
		status2Set[`TMAI_B2_BPV_SAT] = eventPulse.bpvEvent &&
			(bipolarViolCount == CNT16_W'(`TMAI_SAT_MAX16));
	end

	// Event bits have no lasting condition; only the set term keeps them
	assign status2Live = status2Set;

	// latch, clear on read unless burst or still present
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			status1_q <= tmai_alarm_t'(`TMAI_RST_STATUS);
		end else if (rdStatus1 && !burstMode_q) begin
			// Set wins over the read clear
			status1_q <= alarmLevel;
		end else begin
			status1_q <= status1_q | alarmLevel;
		end
	end

	// event latch, set wins over the read clear
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			status2_q <= `TMAI_RST_STATUS;
		end else if (rdStatus2 && !burstMode_q) begin
			status2_q <= status2Live;
		end else begin
			status2_q <= status2_q | status2Set;
		end
	end

	// Read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			regRdData <= 8'h00;
		end else if (regRdStb) begin
			case (regAddr)
				`TMAI_OFF_STATUS_ONE: regRdData <= status1_q;
				`TMAI_OFF_MASK_ONE:   regRdData <= rxIrqMaskOne_q;
				`TMAI_OFF_STATUS_TWO: regRdData <= status2_q;
				`TMAI_OFF_MASK_TWO:   regRdData <= rxIrqMaskTwo_q;
				`TMAI_OFF_CONTROL:    regRdData <= {7'h00, burstMode_q};
				default:              regRdData <= 8'h00;
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end

	assign irqAny = |(status1_q & rxIrqMaskOne_q) |
		|(status2_q & rxIrqMaskTwo_q);

	// registered active-low output, one cycle behind status
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			irq_b <= 1'b1;
		end else begin
			irq_b <= !irqAny;
		end
	end

	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_irq_follows_status: assert property (
		irqAny |=> !irq_b) else $error("irq not low after enabled status");

	a_irq_release: assert property (
		!irqAny |=> irq_b) else $error("irq low with no enabled status");

	a_eight_zero_mask: assert property (
		(status1_q[`TMAI_B1_EIGHT_ZERO] && rxIrqMaskOne_q[7]) |=> !irq_b)
		else $error("eight-zero interrupt not raised");

	a_frame_err_latch: assert property (
		eventPulse.frameBitError |=> status2_q[`TMAI_B2_FRAME_ERR])
		else $error("frame bit error not latched");

	a_bpv_sat_set: assert property (
		(eventPulse.bpvEvent && bipolarViolCount == 16'hffff)
		|=> status2_q[`TMAI_B2_BPV_SAT])
		else $error("violation saturation not latched");

	a_oof_sat_hold: assert property (
		(eventPulse.oofEvent && outOfFrameCount != 8'hff &&
		!status2_q[`TMAI_B2_OOF_SAT]) |=> !status2_q[`TMAI_B2_OOF_SAT])
		else $error("oof saturation set before saturation");

	a_status_hold: assert property (
		(status2_q[`TMAI_B2_CL_CLEAR] && !rdStatus2) |=>
		status2_q[`TMAI_B2_CL_CLEAR])
		else $error("carrier-loss-clear dropped without read");

	a_read_clears: assert property (
		(rdStatus2 && !burstMode_q && !status2Set[`TMAI_B2_CRC_SAT])
		|=> !status2_q[`TMAI_B2_CRC_SAT])
		else $error("status not cleared by read");

	a_burst_keeps: assert property (
		(rdStatus1 && burstMode_q) |=>
		(status1_q == ($past(status1_q) | $past(alarmLevel))))
		else $error("burst read altered status");

	a_blue_clear_set: assert property (
		(blueAlarm_q && !alarmLevel.blueAlarm) |=>
		status2_q[`TMAI_B2_BLUE_CLEAR])
		else $error("blue alarm clear not latched");

	// Event sources checked against the set rules in their own terms
	a_severe_frm_set: assert property (
		(eventPulse.framingBitSeen && eventPulse.frameBitError &&
		(frmErrHist_q[`TMAI_SEF_SPAN-2:0] != '0))
		|=> status2_q[`TMAI_B2_SEVERE_FRM])
		else $error("severe framing event not latched");

	a_cl_clear_set: assert property (
		($fell(alarmLevel.carrierLoss) && $past(rst_b))
		|=> status2_q[`TMAI_B2_CL_CLEAR])
		else $error("carrier loss clear not latched");

	a_fe_sat_set: assert property (
		(eventPulse.frameBitError && frameErrorCount == 8'hff)
		|=> status2_q[`TMAI_B2_FE_SAT])
		else $error("frame error saturation not latched");

	a_oof_sat_set: assert property (
		(eventPulse.oofEvent && outOfFrameCount == 8'hff)
		|=> status2_q[`TMAI_B2_OOF_SAT])
		else $error("oof saturation not latched");

	a_crc_sat_set: assert property (
		(eventPulse.crcErrEvent && crcErrorCount == 8'hff)
		|=> status2_q[`TMAI_B2_CRC_SAT])
		else $error("crc saturation not latched");

	// Each enabled mask bit must pull the pin low on the next edge
	a_severe_mask: assert property (
		(status2_q[7] && rxIrqMaskTwo_q[7]) |=> !irq_b)
		else $error("severe framing interrupt not raised");

	a_clc_mask: assert property (
		(status2_q[6] && rxIrqMaskTwo_q[6]) |=> !irq_b)
		else $error("carrier loss clear interrupt not raised");

	a_clear_err_masks: assert property (
		((status2_q[5:4] & rxIrqMaskTwo_q[5:4]) != 2'b00)
		|=> !irq_b)
		else $error("blue clear or frame error interrupt not raised");

	a_sat_masks: assert property (
		((status2_q[3:0] & rxIrqMaskTwo_q[3:0]) != 4'h0)
		|=> !irq_b)
		else $error("saturation interrupt not raised");

	a_mask_one_gate: assert property (
		((status1_q[6:0] & rxIrqMaskOne_q[6:0]) != 7'h00)
		|=> !irq_b)
		else $error("first register interrupt not raised");

	// Steps from an enabled frame bit error to the pin
	sequence s_fe_enabled;
		eventPulse.frameBitError &&
		rxIrqMaskTwo_q[`TMAI_B2_FRAME_ERR] && !regWrStb;
	endsequence

	sequence s_fe_latched_low;
		status2_q[`TMAI_B2_FRAME_ERR] ##1 !irq_b;
	endsequence

	a_frame_err_pin: assert property (
		s_fe_enabled |=> s_fe_latched_low)
		else $error("frame bit error did not reach the pin");

	// Steps from an enabled level alarm to the pin
	sequence s_level_enabled;
		|(alarmLevel & rxIrqMaskOne_q) && !regWrStb;
	endsequence

	sequence s_level_latched_low;
		|(status1_q & rxIrqMaskOne_q) ##1 !irq_b;
	endsequence

	a_level_pin: assert property (
		s_level_enabled |=> s_level_latched_low)
		else $error("level alarm did not reach the pin");

endmodule

// ### test/tb_top.sv
// Self-checking bench for the alarm interrupt block
`timescale 1ns/1ps
`include "tmai_regs.svh"
`define TB_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top
	import tmai_pkg::*;
;
	logic        ref_clk, rst_b, regWrStb, regRdStb, irq_b, rdPend;
	logic [3:0]  regAddr;
	logic [7:0]  regWrData, regRdData, feCnt, oofCnt, crcCnt, m, lvl;
	logic [15:0] bpvCnt;
	tmai_alarm_t alarmLevel;
	tmai_event_t eventPulse;
	int          n_errors, checks_done, cyc;
	logic [7:0]  expQ[$];
	logic [7:0]  expV;
	logic [4:0]  ev[8] = '{5'h18, 5'h18, 5'h04, 5'h04, 5'h02, 5'h01,
		5'h02, 5'h01};
	logic        sat[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
	logic [7:0]  ex[8] = '{8'h10, 8'h98, 8'h04, 8'h00, 8'h02, 8'h01,
		8'h00, 8'h01};

	tmai_host host (.ref_clk(ref_clk), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb));
	tmai_alarm_irq dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regRdData(regRdData),
		.alarmLevel(alarmLevel), .eventPulse(eventPulse),
		.frameErrorCount(feCnt), .outOfFrameCount(oofCnt),
		.crcErrorCount(crcCnt), .bipolarViolCount(bpvCnt), .irq_b(irq_b));

	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rdPend === 1'b1 && expQ.size() > 0) begin
			// Pop once; the compare macro reads its arguments twice
			expV = expQ.pop_front();
			`TB_CHK(regRdData, expV)
		end
		rdPend <= regRdStb;
	end

	// Hang guard well above the run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		expQ.push_back(e);
		host.rd(a);
	endtask

	// Irq level after settling, from masked status
	task automatic chkIrq(input logic [7:0] st, input logic [7:0] mk);
		#1;
		`TB_CHK(irq_b, ~|(st & mk))
		@(posedge ref_clk);
	endtask

	// Event pulse with counters either at their maximum or below it
	task automatic pulse(input logic [4:0] e, input logic s);
		feCnt <= s ? 8'hff : 8'($urandom_range(254));
		oofCnt <= s ? 8'hff : 8'($urandom_range(254));
		crcCnt <= s ? 8'hff : 8'($urandom_range(254));
		bpvCnt <= s ? 16'hffff : 16'($urandom_range(65534));
		eventPulse <= e;
		@(posedge ref_clk);
		eventPulse <= '0;
		@(posedge ref_clk);
	endtask

	initial begin
		void'($urandom(50209));
		{rst_b, rdPend, alarmLevel, eventPulse} = '0;
		{feCnt, oofCnt, crcCnt, bpvCnt} = '0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		// Reset values, unmapped and read-only places
		rd(4'h1, 8'h00);
		rd(4'h3, 8'h00);
		host.wr(4'h2, 8'hff);
		rd(4'h2, 8'h00);
		rd(4'h0, 8'h00);
		rd(4'hf, 8'h00);
		// Event latching and second mask, masked or enabled in turn
		for (int i = 0; i < 8; i++) begin
			m = 8'($urandom);
			m = i[0] ? (m | ex[i]) : (m & ~ex[i]);
			host.wr(4'h3, m);
			rd(4'h3, m);
			pulse(ev[i], sat[i]);
			chkIrq(ex[i], m);
			rd(4'h2, ex[i]);
			rd(4'h2, 8'h00);
			chkIrq(8'h00, m);
		end
		// Carrier and blue alarm ending, then burst reads keep bits
		host.wr(4'h3, 8'h60);
		alarmLevel <= 8'h22;
		@(posedge ref_clk);
		alarmLevel <= '0;
		repeat (2) @(posedge ref_clk);
		chkIrq(8'h60, 8'h60);
		host.wr(4'h4, 8'h01);
		rd(4'h4, 8'h01);
		rd(4'h0, 8'h22);
		rd(4'h2, 8'h60);
		rd(4'h2, 8'h60);
		host.wr(4'h4, 8'h00);
		rd(4'h2, 8'h60);
		rd(4'h2, 8'h00);
		rd(4'h0, 8'h22);
		rd(4'h0, 8'h00);
		host.wr(4'h3, 8'h00);
		// Level alarms with random first mask
		for (int i = 0; i < 6; i++) begin
			lvl = 8'($urandom);
			m = 8'($urandom);
			// First pass always exercises the eight-zero path
			if (i == 0) begin
				lvl[7] = 1'b1;
				m[7] = 1'b1;
			end
			alarmLevel <= lvl;
			host.wr(4'h1, m);
			rd(4'h1, m);
			chkIrq(lvl, m);
			rd(4'h0, lvl);
			alarmLevel <= '0;
			repeat (2) @(posedge ref_clk);
			rd(4'h0, lvl);
			rd(4'h0, 8'h00);
			chkIrq(8'h00, m);
		end
		stop_test();
	end
endmodule

// ### test/tmai_host.sv
// Host model that reaches the alarm block over its register port
`timescale 1ns/1ps
`include "tmai_regs.svh"

module tmai_host (
	// Clock
	input  wire logic                    ref_clk,
	// Register port towards the block
	output logic      [`TMAI_ADDR_W-1:0] regAddr,
	output logic      [7:0]              regWrData,
	output logic                         regWrStb,
	output logic                         regRdStb
);
	// Idle bus from time zero
	initial begin
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
	end

	// Write cycle; a spare cycle keeps strobes from being reassigned at once
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
		regWrData <= ~d;  // Stale data never lingers
		@(posedge ref_clk);
	endtask

	// Read cycle; data is taken by the bench one cycle later
	task automatic rd(input logic [3:0] a);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		regAddr <= ~a;
		@(posedge ref_clk);
	endtask
endmodule
